// [logic/pio_params.svh]
// Purpose: Constants for the processor I/O port interface.
// Assumes: Included by bare name from the package and the design modules.
// Notes:   Widths, reset values, address fill and the instruction cycle count only; no logic lives here.
//
// Overview of operation
// R1 - Input instruction drives port address from constant or register, captures input data.
// R2 - Each input instruction raises read_pulse for exactly one clock.
// R3 - User logic places matching input data on the input bus in time.
// R4 - User logic should register its input multiplexer: select, then present.
// R5 - read_pulse stays out of the input mux; combine with decode for acknowledges.
// R6 - User logic should place input ports at addresses 00 to 0F.
// R7 - Output instruction drives register data and address, qualified by one-cycle write_pulse.
// R8 - Buses may change anytime; write_pulse only on general output instructions.
// R9 - User logic captures output data when write_pulse and address decode match.
// R10 - Every instruction, including I/O, takes exactly two clocks.
// R11 - Sixteen constant ports use address bits 3:0 with constant_write_pulse.
// R12 - User logic ignores address bits 7:4 on constant port writes.
// R13 - User logic may form one-clock pulses from write_pulse and decode.
// R14 - Constant output drives immediate data and 4-bit port, changing no register.
// R15 - User logic may build hybrid ports at 00 to 0F using both pulses.
// R16 - constant_write_pulse lasts one clock, only on constant output instructions.
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

`define PIO_DATA_W        8
`define PIO_ADDR_W        8
`define PIO_KADDR_W       4
`define PIO_REG_IDX_W     4
`define PIO_INSTR_CYCLES  2
`define PIO_RST_DATA      8'h00
`define PIO_RST_ADDR      8'h00
`define PIO_KADDR_HI_FILL 4'h0

`endif

// [logic/pio_pkg.sv]
// Purpose: Types shared by the processor I/O port interface.
// Assumes: pio_params.svh supplies the widths.
// Notes:   Instruction requests and port buses travel as packed structs.
`include "pio_params.svh"

package pio_pkg;

  typedef enum logic [1:0] {
    PIO_OP_OTHER,
    PIO_OP_INPUT,
    PIO_OP_OUTPUT,
    PIO_OP_CONST_OUTPUT
  } pio_op_t;

  typedef struct packed {
    logic                        valid;
    pio_op_t                     op;
    logic                        addr_from_reg;
    logic [`PIO_ADDR_W-1:0]      imm_addr;
    logic [`PIO_ADDR_W-1:0]      reg_addr;
    logic [`PIO_DATA_W-1:0]      src_data;
    logic [`PIO_DATA_W-1:0]      const_data;
    logic [`PIO_REG_IDX_W-1:0]   dest_idx;
  } pio_instr_t;

  typedef struct packed {
    logic [`PIO_ADDR_W-1:0]      port_address_bus;
    logic [`PIO_DATA_W-1:0]      out_data;
  } pio_port_bus_t;

  typedef struct packed {
    logic                        en;
    logic [`PIO_REG_IDX_W-1:0]   idx;
    logic [`PIO_DATA_W-1:0]      data;
  } pio_reg_wr_t;

endpackage

// [logic/pio_phase.sv]
// Purpose: Instruction slot divider: one-cycle enable every instruction period.
// Assumes: Single clock, synchronous active-high reset.
// Notes:   The enable is high in the first cycle after reset release.
`include "pio_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pio_phase
  import pio_pkg::*;
#(
  parameter int CYCLES = `PIO_INSTR_CYCLES
)(
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  output logic      slot_en_o
);

  typedef struct packed {
    logic [7:0] cnt;
  } pio_phase_st_t;

  pio_phase_st_t st_r;
  pio_phase_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (st_r.cnt == 8'(CYCLES - 1))
    begin
      st_nxt.cnt = 8'h00;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign slot_en_o = (st_r.cnt == 8'h00);

endmodule

`default_nettype wire

// [logic/pio_port_unit.sv]
// Purpose: I/O port side of the small 8-bit controller: address, data and strobes.
// Assumes: The core offers one instruction per slot; inputs synchronous to clk_i.
// Notes:   One instruction is taken every two clocks; input data lands one slot later.
`include "pio_params.svh"
`timescale 1ns/1ps
`default_nettype none

module pio_port_unit
  import pio_pkg::*;
#(
  parameter int INSTR_CYCLES = `PIO_INSTR_CYCLES
)(
  input  wire logic                    clk_i,
  input  wire logic                    sys_rst_i,
  input  wire pio_instr_t              instr_i,
  output logic                         instr_ready_o,
  input  wire logic [`PIO_DATA_W-1:0]  in_port_i,
  output pio_port_bus_t                port_o,
  output logic                         read_pulse_o,
  output logic                         write_pulse_o,
  output logic                         constant_write_pulse_o,
  output pio_reg_wr_t                  reg_wr_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    pio_port_bus_t               bus;
    logic                        rd;
    logic                        wr;
    logic                        kwr;
    logic                        cap_pend;
    logic [`PIO_REG_IDX_W-1:0]   cap_idx;
    pio_reg_wr_t                 reg_wr;
  } pio_unit_st_t;

  pio_unit_st_t st_r;
  pio_unit_st_t st_nxt;
  logic         slot_en;

  function automatic logic [`PIO_ADDR_W-1:0] pick_addr(input pio_instr_t ins);
    pick_addr = ins.addr_from_reg ? ins.reg_addr : ins.imm_addr;
  endfunction

  // ---------------------------------------------------------------
  // Instruction slot timing
  // ---------------------------------------------------------------
  pio_phase #(
    .CYCLES (INSTR_CYCLES)
  ) u_phase (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .slot_en_o (slot_en)                                  // see R10
  );

  assign instr_ready_o = slot_en;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rd     = 1'b0;                                 // see R2
    st_nxt.wr     = 1'b0;                                 // see R8
    st_nxt.kwr    = 1'b0;                                 // see R16
    st_nxt.reg_wr.en = 1'b0;
    if (slot_en)
    begin
      // The input bus is sampled one full slot after the address went out,
      // which leaves the user a registered select stage.
      if (st_r.cap_pend)
      begin
        st_nxt.reg_wr.en   = 1'b1;                        // see R1
        st_nxt.reg_wr.idx  = st_r.cap_idx;
        st_nxt.reg_wr.data = in_port_i;                   // see R3, R4
        st_nxt.cap_pend    = 1'b0;
      end
      if (instr_i.valid)
      begin
        case (instr_i.op)
          PIO_OP_INPUT:
          begin
            st_nxt.bus.port_address_bus = pick_addr(instr_i);  // see R1
            st_nxt.rd       = 1'b1;                       // see R2
            st_nxt.cap_pend = 1'b1;
            st_nxt.cap_idx  = instr_i.dest_idx;
          end
          PIO_OP_OUTPUT:
          begin
            st_nxt.bus.port_address_bus = pick_addr(instr_i);  // see R7
            st_nxt.bus.out_data         = instr_i.src_data;
            st_nxt.wr = 1'b1;                             // see R7, R8
          end
          PIO_OP_CONST_OUTPUT:
          begin
            // Upper address bits carry no meaning here; they are held at a fixed fill.
            st_nxt.bus.port_address_bus = {`PIO_KADDR_HI_FILL,
                                           instr_i.imm_addr[`PIO_KADDR_W-1:0]};  // see R11, R14
            st_nxt.bus.out_data         = instr_i.const_data;  // see R14
            st_nxt.kwr = 1'b1;                            // see R11, R16
          end
          default:
          begin
            st_nxt.bus = st_r.bus;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_r                      <= '0;
      st_r.bus.port_address_bus <= `PIO_RST_ADDR;
      st_r.bus.out_data         <= `PIO_RST_DATA;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign port_o                 = st_r.bus;
  assign read_pulse_o           = st_r.rd;
  assign write_pulse_o          = st_r.wr;
  assign constant_write_pulse_o = st_r.kwr;
  assign reg_wr_o               = st_r.reg_wr;

endmodule

`default_nettype wire

// [verification/pio_user_model.sv]
// Purpose: User logic model: registered input mux and a hybrid output port.
// Assumes: Inputs select on address bits 3:0; hybrid port sits at 08.
// Notes:   Input data is selected one clock after the address appears.
`include "pio_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pio_user_model
  import pio_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire pio_port_bus_t         port_i,
  input  wire logic                  wr_i,
  input  wire logic                  kwr_i,
  output logic [`PIO_DATA_W-1:0]     in_port_o,
  output logic [`PIO_DATA_W-1:0]     hyb_o,
  output logic                       port_pulse_o
);
  logic hyb_hit;
  assign hyb_hit = (wr_i && port_i.port_address_bus == 8'h08) ||
                   (kwr_i && port_i.port_address_bus[3:0] == 4'h8);
  // A one-clock pulse decoded from the general write strobe at port 08.
  assign port_pulse_o = wr_i && (port_i.port_address_bus == 8'h08);
  always_ff @(posedge clk_i)
  begin
    in_port_o <= {port_i.port_address_bus[3:0], ~port_i.port_address_bus[3:0]};
    if (sys_rst_i)
      hyb_o <= 8'h00;
    else if (hyb_hit)
      hyb_o <= port_i.out_data;
  end
endmodule
`default_nettype wire

// [verification/pio_port_unit_chk.sv]
// Purpose: Timing checks on the I/O port unit.
// Assumes: One clock; reset disables every check.
// Notes:   Bound to the port unit below.
`include "pio_params.svh"
`timescale 1ns/1ps
`default_nettype none
module pio_port_unit_chk
  import pio_pkg::*;
#(
  parameter int INSTR_CYCLES = 2
)(
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire pio_instr_t             instr_i,
  input  wire logic                   instr_ready_o,
  input  wire logic [`PIO_DATA_W-1:0] in_port_i,
  input  wire pio_port_bus_t          port_o,
  input  wire logic                   read_pulse_o,
  input  wire logic                   write_pulse_o,
  input  wire logic                   constant_write_pulse_o,
  input  wire pio_reg_wr_t            reg_wr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic tk;
  wire logic tk_out;
  wire logic tk_k;
  wire logic [`PIO_ADDR_W-1:0] pa;
  assign tk = instr_ready_o & instr_i.valid;
  assign tk_out = tk && instr_i.op == PIO_OP_OUTPUT;
  assign tk_k = tk && instr_i.op == PIO_OP_CONST_OUTPUT;
  assign pa = instr_i.addr_from_reg ? instr_i.reg_addr : instr_i.imm_addr;
  sequence s_in; tk && instr_i.op == PIO_OP_INPUT; endsequence
  sequence s_out; tk && instr_i.op == PIO_OP_OUTPUT; endsequence
  sequence s_k; tk && instr_i.op == PIO_OP_CONST_OUTPUT; endsequence
  a_rd_follows: assert property (s_in |=> read_pulse_o && port_o.port_address_bus ==
    $past(pa)) else $error("bad read");
  a_rd_single: assert property (read_pulse_o |=> !read_pulse_o) else $error("long read");
  a_wr_follows: assert property (s_out |=> write_pulse_o &&
    port_o.out_data == $past(instr_i.src_data)) else $error("bad write");
  a_wr_cause: assert property (write_pulse_o |-> $past(tk_out))
    else $error("stray write");
  a_kwr_follows: assert property (s_k |=> constant_write_pulse_o &&
    port_o.port_address_bus[3:0] == $past(instr_i.imm_addr[3:0]) &&
    port_o.out_data == $past(instr_i.const_data)) else $error("bad const write");
  a_kwr_cause: assert property (constant_write_pulse_o |->
    $past(tk_k) ##1 !constant_write_pulse_o)
    else $error("stray const write");
  a_slot_period: assert property (instr_ready_o |=> !instr_ready_o ##1 instr_ready_o)
    else $error("bad slot");
  a_in_capture: assert property (s_in |-> ##3 reg_wr_o.en &&
    reg_wr_o.data == $past(in_port_i) && reg_wr_o.idx == $past(instr_i.dest_idx, 3))
    else $error("bad capture");
endmodule
bind pio_port_unit pio_port_unit_chk #(.INSTR_CYCLES(INSTR_CYCLES)) i_chk (.clk_i(clk_i),
  .sys_rst_i(sys_rst_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
  .in_port_i(in_port_i), .port_o(port_o), .read_pulse_o(read_pulse_o),
  .write_pulse_o(write_pulse_o), .constant_write_pulse_o(constant_write_pulse_o),
  .reg_wr_o(reg_wr_o));
`default_nettype wire

// [verification/tb.sv]
// Purpose: Self-checking bench for the I/O port unit.
// Assumes: 40 ns clock; reset held 16 cycles.
// Notes:   Random instructions from a fixed-seed LFSR, all ops first.
`include "pio_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb
  import pio_pkg::*;
;
  logic          clk_i, sys_rst_i, rdy, rp, wp, kp, tk, ev, pls;
  pio_instr_t    ins, cur;
  pio_port_bus_t pb;
  pio_reg_wr_t   rw;
  logic [7:0]    inp, hyb, ea, ed, eh, ein, a;
  logic [3:0]    ei;
  logic [31:0]   r, q;
  int            err_total, cmp_count, wt;
  pio_port_unit i_pio_port_unit (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .instr_i(ins),
    .instr_ready_o(rdy), .in_port_i(inp), .port_o(pb), .read_pulse_o(rp),
    .write_pulse_o(wp), .constant_write_pulse_o(kp), .reg_wr_o(rw));
  pio_user_model i_pio_user_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .port_i(pb),
    .wr_i(wp), .kwr_i(kp), .in_port_o(inp), .hyb_o(hyb), .port_pulse_o(pls));
  function automatic logic [31:0] nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [7:0] exp_in(input logic [7:0] ad);
    return {ad[3:0], ~ad[3:0]};
  endfunction
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    clk_i = 0;
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    sys_rst_i = 1; ins = '0; err_total = 0; cmp_count = 0; r = 32'h13e2c9ea;
    ea = 0; ed = 0; eh = 0; ev = 0; ein = 0; ei = 0;
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 0;
    for (int i = 0; i < 300; i++)
    begin
      wt = 0;
      while (!rdy && wt < 4)
      begin
        @(posedge clk_i);
        #1 wt++;
      end
      if (wt == 4)
      begin
        err_total++;
        conclude();
      end
      q = nx(r);
      r = nx(q);
      ins.valid = (i < 8) | q[0];
      ins.op = (i < 8) ? pio_op_t'(i[1:0]) : pio_op_t'(q[2:1]);
      ins.addr_from_reg = q[3];
      ins.imm_addr = (i < 8) ? 8'hf8 : (q[4] ? {4'h0, q[11:8]} : q[15:8]);
      ins.reg_addr = (i < 8) ? 8'h08 : (q[5] ? {4'h0, q[19:16]} : q[23:16]);
      {ins.src_data, ins.const_data, ins.dest_idx} = r[19:0];
      cur = ins;
      tk = ins.valid;
      a = cur.addr_from_reg ? cur.reg_addr : cur.imm_addr;
      if (tk && cur.op inside {PIO_OP_INPUT, PIO_OP_OUTPUT}) ea = a;
      if (tk && cur.op == PIO_OP_OUTPUT) ed = cur.src_data;
      if (tk && cur.op == PIO_OP_OUTPUT && a == 8'h08) eh = ed;
      if (tk && cur.op == PIO_OP_CONST_OUTPUT)
      begin
        ea = {4'h0, cur.imm_addr[3:0]};
        ed = cur.const_data;
        if (ea == 8'h08) eh = ed;
      end
      @(posedge clk_i);
      #1 ins.op = PIO_OP_INPUT;
      chk("read", rp, tk && cur.op == PIO_OP_INPUT);
      chk("write", wp, tk && cur.op == PIO_OP_OUTPUT);
      chk("kwrite", kp, tk && cur.op == PIO_OP_CONST_OUTPUT);
      chk("pulse", pls, tk && cur.op == PIO_OP_OUTPUT && a == 8'h08);
      chk("addr", pb.port_address_bus, ea);
      chk("data", pb.out_data, ed);
      chk("rw_en", rw.en, ev);
      if (ev) chk("rw_data", rw.data, ein);
      if (ev) chk("rw_idx", rw.idx, ei);
      ev = tk && cur.op == PIO_OP_INPUT;
      ein = exp_in(ea);
      ei = cur.dest_idx;
      @(posedge clk_i);
      #1 chk("pulses", {5'h00, rp, wp, kp}, 8'h00);
      chk("hybrid", hyb, eh);
      chk("ready", {7'h00, rdy}, 8'h01);
    end
    conclude();
  end
endmodule
`default_nettype wire
